// *** rtl/dps_consts.svh ***
//------------------------------------------------------------
// Contract
// - Transition from previous and current clock-enable samples
// - No refresh performed during power-down
// - Command inputs ignored in power-down, self refresh
// - Termination never steers power-state; off in self refresh
// - Undefined combinations are flagged illegal
// - Write auto precharge closes bank after recovery
// - Write recovery lives in mode bits 9-11
// - Idle banks give precharge, open row active power-down
// - Mode bit 12 selects fast or slow active power-down exit
//------------------------------------------------------------
`ifndef DPS_CONSTS_SVH
`define DPS_CONSTS_SVH
// Register byte offsets
`define DPS_OFS_CTRL 8'h00
`define DPS_OFS_STATUS 8'h04
`define DPS_OFS_MODE 8'h08
`define DPS_OFS_EXTMODE 8'h0c
`define DPS_OFS_REFCNT 8'h10
// Control fields and reset value
`define DPS_CTRL_CHECK_BIT 0
`define DPS_CTRL_CLEAR_BIT 1
`define DPS_CTRL_RESET 1'b1
// Mode register fields
`define DPS_MODE_WR_LSB 9
`define DPS_MODE_WR_MSB 11
`define DPS_MODE_SLOW_BIT 12
`define DPS_EXT_RTT_A 6
`define DPS_EXT_RTT_B 2
// Timing counts in link clock edges
`define DPS_XSRD_CK 8'd200
`define DPS_CKE_MIN_CK 2'd3
`endif

// *** rtl/dps_pkg.sv ***
package dps_pkg;
    // Power states
    typedef enum logic [2:0] {
        DPS_IDLE = 3'b000,
        DPS_ACTIVE = 3'b001,
        DPS_PPD = 3'b010,
        DPS_APD = 3'b011,
        DPS_SREF = 3'b100
    } dps_state_t;
    // Decoded command kinds
    typedef enum logic [2:0] {
        DPS_OP_NOP = 3'b000,
        DPS_OP_ACT = 3'b001,
        DPS_OP_RD = 3'b010,
        DPS_OP_WR = 3'b011,
        DPS_OP_PRE = 3'b100,
        DPS_OP_REF = 3'b101,
        DPS_OP_LM = 3'b110,
        DPS_OP_OTHER = 3'b111
    } dps_op_t;
    // Command strobes, active low
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } dps_cmd_t;
    // All sampled pins as one bundle
    typedef struct packed {
        logic ck;
        logic cke;
        logic odt;
        dps_cmd_t cmd;
        logic [2:0] ba;
        logic [12:0] a;
    } dps_pins_t;
    // Command decode
    function automatic dps_op_t dps_decode(input dps_cmd_t c);
        dps_op_t op;
        op = DPS_OP_OTHER;
        if (c.cs_n) begin
            op = DPS_OP_NOP;
        end else begin
            case ({c.ras_n, c.cas_n, c.we_n})
                3'b111: op = DPS_OP_NOP;
                3'b011: op = DPS_OP_ACT;
                3'b101: op = DPS_OP_RD;
                3'b100: op = DPS_OP_WR;
                3'b010: op = DPS_OP_PRE;
                3'b001: op = DPS_OP_REF;
                3'b000: op = DPS_OP_LM;
                default: op = DPS_OP_OTHER;
            endcase
        end
        return op;
    endfunction : dps_decode
endpackage : dps_pkg

// *** rtl/dps_top.sv ***
// The implementer's own choices: the address map and the AHB-Lite register port.
`include "dps_consts.svh"
module dps_top #(
    parameter int XARD_CK = 2,
    parameter int XARDS_CK = 6
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic CK,
    input wire logic CKE,
    input wire logic ODT,
    input wire dps_pkg::dps_cmd_t CMD,
    input wire logic [2:0] BA,
    input wire logic [12:0] ADDR,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    output logic [2:0] PWR_STATE,
    output logic ODT_ACTIVE,
    output logic READ_READY,
    output logic ILLEGAL
);
    import dps_pkg::*;

    //------------------------------------------------------------
    // Pin synchronisers
    //------------------------------------------------------------
    dps_pins_t pin_s1_reg; // First stage, read by second only
    dps_pins_t pin_s2_reg; // Second stage
    logic ck_d_reg; // Delayed link clock for edge find
    logic ck_rise; // One CLK cycle per link clock rise
    dps_op_t op; // Command sampled at this link edge

    // Two flops on every pin, then edge detect
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            ck_d_reg <= 1'b0;
        end else begin
            pin_s1_reg <= {CK, CKE, ODT, CMD, BA, ADDR};
            pin_s2_reg <= pin_s1_reg;
            ck_d_reg <= pin_s2_reg.ck;
        end
    end

    assign ck_rise = pin_s2_reg.ck & ~ck_d_reg;
    assign op = dps_decode(pin_s2_reg.cmd);

    //------------------------------------------------------------
    // Power-state core
    //------------------------------------------------------------
    dps_state_t state_reg, state_next; // Power state
    logic cke_prev_reg, cke_prev_next; // Enable at previous edge
    logic [1:0] hold_reg, hold_next; // Edges since enable change
    logic [7:0] banks_reg, banks_next; // Open row per bank
    logic [12:0] mode_reg, mode_next; // mode_cfg_register copy
    logic [12:0] ext_reg, ext_next; // extended_mode_cfg_register copy
    logic [7:0] rd_block_reg, rd_block_next; // Edges until read allowed
    logic [3:0] wrap_cnt_reg, wrap_cnt_next; // Write recovery countdown
    logic [2:0] wrap_bank_reg, wrap_bank_next; // Bank to auto-close
    logic wrap_busy_reg, wrap_busy_next; // Auto precharge pending
    logic [15:0] refcnt_reg, refcnt_next; // Refresh commands seen
    logic illegal_reg, illegal_next; // Sticky illegal flag
    logic odt_act_reg, odt_act_next; // Termination in effect
    logic [7:0] banks_eff; // Open rows not about to close
    logic [3:0] wr_clocks; // Recovery from mode field
    logic bad; // Illegal event at this edge
    logic ctrl_check_reg, ctrl_check_next; // Illegal detection on
    logic clr_illegal; // Software clear strobe

    assign wr_clocks = {1'b0, mode_reg[`DPS_MODE_WR_MSB:`DPS_MODE_WR_LSB]} + 4'h1;
    assign banks_eff = banks_reg & ~(wrap_busy_reg ? (8'h01 << wrap_bank_reg) : 8'h00);

    // Next-state logic, core state acts only on link clock rises; illegal clear and termination follow every CLK
    always_comb begin
        state_next = state_reg;
        cke_prev_next = cke_prev_reg;
        hold_next = hold_reg;
        banks_next = banks_reg;
        mode_next = mode_reg;
        ext_next = ext_reg;
        rd_block_next = rd_block_reg;
        wrap_cnt_next = wrap_cnt_reg;
        wrap_bank_next = wrap_bank_reg;
        wrap_busy_next = wrap_busy_reg;
        refcnt_next = refcnt_reg;
        bad = 1'b0;
        if (ck_rise) begin
            // Auto precharge after write recovery
            if (wrap_busy_reg) begin
                wrap_cnt_next = wrap_cnt_reg - 4'h1;
                if (wrap_cnt_reg == 4'h1) begin
                    wrap_busy_next = 1'b0;
                    banks_next[wrap_bank_reg] = 1'b0;
                end
            end
            // Read blocking interval after exit
            if (rd_block_reg != 8'h00) begin
                rd_block_next = rd_block_reg - 8'h01;
            end
            // Count registrations of the same enable level
            cke_prev_next = pin_s2_reg.cke;
            if (pin_s2_reg.cke != cke_prev_reg) begin
                hold_next = 2'd1;
                if (hold_reg < `DPS_CKE_MIN_CK) begin
                    bad = 1'b1;
                end
            end else if (hold_reg != 2'd3) begin
                hold_next = hold_reg + 2'd1;
            end
            case ({cke_prev_reg, pin_s2_reg.cke})
                // Normal operation: commands decoded
                2'b11: begin
                    case (op)
                        DPS_OP_ACT: banks_next[pin_s2_reg.ba] = 1'b1;
                        DPS_OP_PRE: begin
                            if (pin_s2_reg.a[10]) begin
                                banks_next = 8'h00;
                            end else begin
                                banks_next[pin_s2_reg.ba] = 1'b0;
                            end
                        end
                        DPS_OP_RD: bad = bad | (rd_block_reg != 8'h00);
                        DPS_OP_WR: begin
                            if (pin_s2_reg.a[10]) begin
                                wrap_busy_next = 1'b1;
                                wrap_bank_next = pin_s2_reg.ba;
                                wrap_cnt_next = wr_clocks;
                            end
                        end
                        DPS_OP_REF: begin
                            bad = bad | (banks_reg != 8'h00);
                            refcnt_next = refcnt_reg + 16'h0001;
                        end
                        DPS_OP_LM: begin
                            if (pin_s2_reg.ba == 3'd0) begin
                                mode_next = pin_s2_reg.a;
                            end else if (pin_s2_reg.ba == 3'd1) begin
                                ext_next = pin_s2_reg.a;
                            end
                        end
                        default: ;
                    endcase
                    state_next = (banks_next != 8'h00) ? DPS_ACTIVE : DPS_IDLE;
                end
                // Enable falls: power-down or self refresh entry
                2'b10: begin
                    if (op == DPS_OP_NOP) begin
                        state_next = (banks_eff == 8'h00) ? DPS_PPD : DPS_APD;
                    end else if (op == DPS_OP_REF && banks_eff == 8'h00) begin
                        state_next = DPS_SREF;
                    end else begin
                        bad = 1'b1;
                    end
                end
                // Enable rises: exit, command must be NOP
                2'b01: begin
                    bad = bad | (op != DPS_OP_NOP);
                    case (state_reg)
                        DPS_SREF: begin
                            state_next = DPS_IDLE;
                            rd_block_next = `DPS_XSRD_CK;
                        end
                        DPS_APD: begin
                            state_next = (banks_next != 8'h00) ? DPS_ACTIVE : DPS_IDLE;
                            rd_block_next = mode_reg[`DPS_MODE_SLOW_BIT] ? 8'(XARDS_CK) : 8'(XARD_CK);
                        end
                        default: state_next = (banks_next != 8'h00) ? DPS_ACTIVE : DPS_IDLE;
                    endcase
                end
                // Both low: state kept, inputs ignored
                default: ;
            endcase
        end
        // Set wins over software clear
        illegal_next = (illegal_reg & ~clr_illegal) | (bad & ctrl_check_reg);
        // Termination ignored by state logic, off in self refresh
        odt_act_next = pin_s2_reg.odt & (ext_reg[`DPS_EXT_RTT_A] | ext_reg[`DPS_EXT_RTT_B])
                       & (state_reg != DPS_SREF);
    end

    // Core registers
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state_reg <= DPS_IDLE;
            cke_prev_reg <= 1'b0;
            hold_reg <= 2'd3;
            banks_reg <= 8'h00;
            mode_reg <= 13'h0000;
            ext_reg <= 13'h0000;
            rd_block_reg <= 8'h00;
            wrap_cnt_reg <= 4'h0;
            wrap_bank_reg <= 3'h0;
            wrap_busy_reg <= 1'b0;
            refcnt_reg <= 16'h0000;
            illegal_reg <= 1'b0;
            odt_act_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cke_prev_reg <= cke_prev_next;
            hold_reg <= hold_next;
            banks_reg <= banks_next;
            mode_reg <= mode_next;
            ext_reg <= ext_next;
            rd_block_reg <= rd_block_next;
            wrap_cnt_reg <= wrap_cnt_next;
            wrap_bank_reg <= wrap_bank_next;
            wrap_busy_reg <= wrap_busy_next;
            refcnt_reg <= refcnt_next;
            illegal_reg <= illegal_next;
            odt_act_reg <= odt_act_next;
        end
    end

    //------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    //------------------------------------------------------------
    logic ph_valid_reg, ph_valid_next; // Write data phase pending
    logic [7:0] ph_addr_reg, ph_addr_next; // Latched write offset
    logic [31:0] hrdata_reg, hrdata_next; // Read data
    logic addr_ok; // Valid address phase

    assign addr_ok = HSEL & HTRANS[1] & HREADY;
    assign clr_illegal = ph_valid_reg & (ph_addr_reg == `DPS_OFS_CTRL) & HWDATA[`DPS_CTRL_CLEAR_BIT];

    // Address decode and read mux
    always_comb begin
        ph_valid_next = addr_ok & HWRITE;
        ph_addr_next = addr_ok ? HADDR[7:0] : ph_addr_reg;
        ctrl_check_next = ctrl_check_reg;
        hrdata_next = hrdata_reg;
        if (ph_valid_reg && ph_addr_reg == `DPS_OFS_CTRL) begin
            ctrl_check_next = HWDATA[`DPS_CTRL_CHECK_BIT];
        end
        if (addr_ok && !HWRITE) begin
            case (HADDR[7:0])
                `DPS_OFS_CTRL: hrdata_next = {31'h0, ctrl_check_reg};
                `DPS_OFS_STATUS: hrdata_next = {16'h0, banks_reg, 3'h0,
                                                rd_block_reg == 8'h00, illegal_reg, state_reg};
                `DPS_OFS_MODE: hrdata_next = {19'h0, mode_reg};
                `DPS_OFS_EXTMODE: hrdata_next = {19'h0, ext_reg};
                `DPS_OFS_REFCNT: hrdata_next = {16'h0, refcnt_reg};
                default: hrdata_next = 32'h0000_0000; // Unmapped reads zero
            endcase
        end
    end

    // Bus registers
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ph_valid_reg <= 1'b0;
            ph_addr_reg <= 8'h00;
            hrdata_reg <= 32'h0000_0000;
            ctrl_check_reg <= `DPS_CTRL_RESET;
        end else begin
            ph_valid_reg <= ph_valid_next;
            ph_addr_reg <= ph_addr_next;
            hrdata_reg <= hrdata_next;
            ctrl_check_reg <= ctrl_check_next;
        end
    end

    //------------------------------------------------------------
    // Outputs, all from flops
    //------------------------------------------------------------
    logic ready_reg; // Always ready
    logic resp_reg; // Always OKAY
    logic rd_ok_reg; // Read allowed
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ready_reg <= 1'b1;
            resp_reg <= 1'b0;
            rd_ok_reg <= 1'b1;
        end else begin
            ready_reg <= 1'b1;
            resp_reg <= 1'b0;
            rd_ok_reg <= (rd_block_next == 8'h00);
        end
    end
    assign HRDATA = hrdata_reg;
    assign HREADYOUT = ready_reg;
    assign HRESP = resp_reg;
    assign PWR_STATE = state_reg;
    assign ODT_ACTIVE = odt_act_reg;
    assign READ_READY = rd_ok_reg;
    assign ILLEGAL = illegal_reg;

    //------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    logic in_pd; // Either power-down
    assign in_pd = (state_reg == DPS_PPD) || (state_reg == DPS_APD);

    a_low_low_hold: assert property (ck_rise && !cke_prev_reg && !pin_s2_reg.cke |=> $stable(state_reg))
        else $error("state moved with enable low twice");
    a_ppd_entry: assert property (ck_rise && cke_prev_reg && !pin_s2_reg.cke && op == DPS_OP_NOP
        && banks_eff == 8'h00 |=> state_reg == DPS_PPD) else $error("precharge power-down not entered");
    a_apd_entry: assert property (ck_rise && cke_prev_reg && !pin_s2_reg.cke && op == DPS_OP_NOP
        && banks_eff != 8'h00 |=> state_reg == DPS_APD) else $error("active power-down not entered");
    a_no_pd_refresh: assert property (in_pd |=> $stable(refcnt_reg))
        else $error("refresh counted in power-down");
    a_cmd_ignored: assert property ((in_pd || state_reg == DPS_SREF) && ck_rise && !pin_s2_reg.cke
        |=> $stable(mode_reg) && $stable(ext_reg)) else $error("command taken while asleep");
    a_odt_sref_off: assert property (state_reg == DPS_SREF |=> !odt_act_reg)
        else $error("termination active in self refresh");
    a_bad_entry: assert property (ck_rise && ctrl_check_reg && cke_prev_reg && !pin_s2_reg.cke
        && op != DPS_OP_NOP && op != DPS_OP_REF |=> illegal_reg) else $error("illegal entry not flagged");
    a_wr_load: assert property (ck_rise && cke_prev_reg && pin_s2_reg.cke && op == DPS_OP_WR
        && pin_s2_reg.a[10] |=> wrap_busy_reg && wrap_cnt_reg == {1'b0, $past(mode_reg[11:9])} + 4'h1)
        else $error("write recovery count wrong");
    a_wrap_close: assert property (ck_rise && wrap_busy_reg && wrap_cnt_reg == 4'h1
        |=> !wrap_busy_reg ##0 !banks_reg[wrap_bank_reg]) else $error("auto precharge did not close");
    a_slow_exit: assert property (ck_rise && state_reg == DPS_APD && !cke_prev_reg && pin_s2_reg.cke
        && mode_reg[12] |=> rd_block_reg == 8'(XARDS_CK)) else $error("slow exit count wrong");

    c_ppd: cover property (state_reg == DPS_IDLE ##1 state_reg == DPS_PPD);
    c_apd: cover property (state_reg == DPS_ACTIVE ##1 state_reg == DPS_APD);
    c_sref: cover property (state_reg == DPS_SREF ##1 state_reg == DPS_IDLE);
endmodule : dps_top

// *** bench/dps_ctrl_model.sv ***
module dps_ctrl_model (
    input wire logic clk,
    output logic ck,
    output logic cke,
    output logic odt,
    output dps_pkg::dps_cmd_t cmd,
    output logic [2:0] ba,
    output logic [12:0] addr
);
    timeunit 1ns;
    timeprecision 1ns;
    import dps_pkg::*;

    //----------------------------------------------------------
    // Link clock and start values
    //----------------------------------------------------------
    // Free-running link clock, phase unrelated to clk
    initial begin
        ck = 1'b0;
        cke = 1'b0;
        odt = 1'b0;
        cmd = 4'hf;
        ba = 3'h0;
        addr = 13'h0000;
        #137;
        forever #400 ck = ~ck;
    end

    //----------------------------------------------------------
    // Pin driving
    //----------------------------------------------------------
    // One command and enable level, held on both sides of one link edge
    task automatic step(input logic e, input logic [3:0] c, input logic [2:0] b, input logic [12:0] a);
        cke <= e;
        cmd <= c;
        ba <= b;
        addr <= a;
        @(posedge ck);
        @(negedge ck);
        @(posedge clk);
    endtask : step

    // Realign after other traffic: just past a falling link edge
    task automatic sync();
        @(negedge ck);
        @(posedge clk);
    endtask : sync

    // Termination level, always a defined high or low
    task automatic set_odt(input logic v);
        odt <= v;
    endtask : set_odt
endmodule : dps_ctrl_model

// *** bench/dps_top_bench.sv ***
`define CHK(got, exp) \
    begin \
        compares++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("[ERR] %0t ns: got %h expected %h", $time, got, exp); \
        end \
    end

module dps_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import dps_pkg::*;

    //----------------------------------------------------------
    // Codes and signals
    //----------------------------------------------------------
    // Strobes {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] NOP = 4'h7;
    localparam logic [3:0] ACT = 4'h3;
    localparam logic [3:0] RD = 4'h5;
    localparam logic [3:0] WR = 4'h4;
    localparam logic [3:0] PRE = 4'h2;
    localparam logic [3:0] REF = 4'h1;
    localparam logic [3:0] LM = 4'h0;
    logic clk; // System clock
    logic nrst; // Reset, active low
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    wire logic hready; // Single slave drives the bus ready
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [2:0] pwr_state;
    logic odt_active;
    logic read_ready;
    logic illegal;
    logic ck;
    logic cke;
    logic odt;
    dps_cmd_t cmd;
    logic [2:0] ba;
    logic [12:0] addr;
    logic [31:0] rdata; // Last word read
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;

    assign hready = hreadyout;

    //----------------------------------------------------------
    // Instances
    //----------------------------------------------------------
    dps_top dps_top_i (
        .CLK(clk), .NRST(nrst), .CK(ck), .CKE(cke), .ODT(odt), .CMD(cmd), .BA(ba), .ADDR(addr),
        .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
        .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .PWR_STATE(pwr_state),
        .ODT_ACTIVE(odt_active), .READ_READY(read_ready), .ILLEGAL(illegal)
    );
    dps_ctrl_model dps_ctrl_model_i (
        .clk(clk), .ck(ck), .cke(cke), .odt(odt), .cmd(cmd), .ba(ba), .addr(addr)
    );

    //----------------------------------------------------------
    // Tasks
    //----------------------------------------------------------
    task automatic step(input logic e, input logic [3:0] c, input logic [2:0] b, input logic [12:0] a);
        dps_ctrl_model_i.step(e, c, b, a);
    endtask : step

    task automatic nops(input int n, input logic e);
        repeat (n) begin
            step(e, NOP, 3'h0, 13'h0000);
        end
    endtask : nops

    // Single word transfer; waits for ready in both phases
    task automatic bus_xfer(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        hsel <= 1'b0;
        dps_ctrl_model_i.sync();
    endtask : bus_xfer

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        bus_xfer(1'b0, a, 32'h0, rdata);
        `CHK(rdata, exp)
        `CHK(hresp, 1'b0)
    endtask : rd_chk

    // Fall with NOP, three low edges of ignored reads, rise with NOP
    task automatic pd(input logic [2:0] exp);
        step(1'b0, NOP, 3'h0, 13'h0000);
        `CHK(pwr_state, exp)
        repeat (3) begin
            step(1'b0, RD, 3'h5, 13'h1abc);
        end
        `CHK(pwr_state, exp)
        `CHK(illegal, 1'b0)
        `CHK(odt_active, odt)
        step(1'b1, NOP, 3'h0, 13'h0000);
    endtask : pd

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    //----------------------------------------------------------
    // Clock and hang guard
    //----------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Whole run needs well under 6000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 12000) begin
            mismatches++;
            $display("[ERR] %0t ns: run timed out", $time);
            finish_test();
        end
    end

    //----------------------------------------------------------
    // Test sequence
    //----------------------------------------------------------
    initial begin
        nrst = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        // Reset values, read-only and unmapped places
        `CHK(pwr_state, 3'h0)
        `CHK(read_ready, 1'b1)
        rd_chk(32'h00, 32'h1);
        rd_chk(32'h14, 32'h0);
        bus_xfer(1'b1, 32'h04, 32'hffffffff, rdata);
        rd_chk(32'h04, 32'h10);
        $display("test reset done");
        // Enable up, load slow-exit mode and termination setting
        nops(4, 1'b1);
        `CHK(illegal, 1'b0)
        step(1'b1, LM, 3'h0, 13'h1200);
        step(1'b1, LM, 3'h1, 13'h0004);
        nops(3, 1'b1);
        rd_chk(32'h08, 32'h1200);
        rd_chk(32'h0c, 32'h0004);
        step(1'b1, REF, 3'h0, 13'h0000);
        nops(2, 1'b1);
        rd_chk(32'h10, 32'h1);
        $display("test setup done");
        // Active power-down, slow exit, one edge after activate
        step(1'b1, ACT, 3'h2, 13'h0000);
        `CHK(pwr_state, 3'h1)
        dps_ctrl_model_i.set_odt(1'b1);
        pd(3'h3);
        dps_ctrl_model_i.set_odt(1'b0);
        `CHK(pwr_state, 3'h1)
        `CHK(read_ready, 1'b0)
        nops(3, 1'b1);
        `CHK(read_ready, 1'b0)
        nops(5, 1'b1);
        `CHK(read_ready, 1'b1)
        rd_chk(32'h04, 32'h0411);
        $display("test slow exit done");
        // Fast exit after a new mode load
        step(1'b1, PRE, 3'h0, 13'h0400);
        `CHK(pwr_state, 3'h0)
        nops(3, 1'b1);
        step(1'b1, LM, 3'h0, 13'h0200);
        nops(3, 1'b1);
        step(1'b1, ACT, 3'h0, 13'h0000);
        pd(3'h3);
        nops(3, 1'b1);
        `CHK(read_ready, 1'b1)
        $display("test fast exit done");
        // Write with auto precharge, then precharge power-down
        step(1'b1, PRE, 3'h0, 13'h0400);
        step(1'b1, ACT, 3'h1, 13'h0000);
        step(1'b1, WR, 3'h1, 13'h0400);
        nops(6, 1'b1);
        pd(3'h2);
        `CHK(pwr_state, 3'h0)
        $display("test write precharge done");
        // Self refresh entry and exit
        nops(3, 1'b1);
        dps_ctrl_model_i.set_odt(1'b1);
        step(1'b0, REF, 3'h0, 13'h0000);
        `CHK(pwr_state, 3'h4)
        `CHK(odt_active, 1'b0)
        repeat (3) begin
            step(1'b0, ACT, 3'h3, 13'h0555);
        end
        `CHK(pwr_state, 3'h4)
        dps_ctrl_model_i.set_odt(1'b0);
        step(1'b1, NOP, 3'h0, 13'h0000);
        `CHK(pwr_state, 3'h0)
        `CHK(read_ready, 1'b0)
        nops(190, 1'b1);
        `CHK(read_ready, 1'b0)
        nops(12, 1'b1);
        `CHK(read_ready, 1'b1)
        `CHK(illegal, 1'b0)
        $display("test self refresh done");
        // Undefined transitions, clearing, check disabled
        step(1'b0, ACT, 3'h0, 13'h0000);
        `CHK(illegal, 1'b1)
        nops(3, 1'b0);
        nops(4, 1'b1);
        bus_xfer(1'b1, 32'h00, 32'h3, rdata);
        `CHK(illegal, 1'b0)
        rd_chk(32'h00, 32'h1);
        step(1'b0, NOP, 3'h0, 13'h0000);
        step(1'b1, NOP, 3'h0, 13'h0000);
        `CHK(illegal, 1'b1)
        nops(3, 1'b1);
        bus_xfer(1'b1, 32'h00, 32'h2, rdata);
        step(1'b0, ACT, 3'h0, 13'h0000);
        `CHK(illegal, 1'b0)
        nops(3, 1'b0);
        nops(4, 1'b1);
        bus_xfer(1'b1, 32'h00, 32'h1, rdata);
        $display("test illegal done");
        finish_test();
    end
endmodule : dps_top_bench
